/* common/psi_defines.vh */
`ifndef PSI_DEFINES_VH
`define PSI_DEFINES_VH
// bus widths
`define PSI_AD_W 64
`define PSI_CHK_W 8
`define PSI_CMD_W 9
// request kinds on the user side
`define PSI_KIND_READ 2'h0
`define PSI_KIND_WRITE 2'h1
`define PSI_KIND_INVAL 2'h2
`define PSI_KIND_UPDATE 2'h3
// command bus: bit 8 marks a data identifier, bits 1:0 carry the kind
`define PSI_CMD_DATA_BIT 8
// fifo shape
`define PSI_FIFO_DEPTH 16
`define PSI_FIFO_AW 4
// request entry layout {kind, cmd, addr/data}
`define PSI_ENT_W 75
`endif

/* core/psi_fifo.v */
`timescale 1ns/10ps
module psi_fifo #(
   parameter WIDTH = 75,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys,
   input wire rst_n,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_r;
   reg [AW-1:0] rdPtr_r;
   reg [AW:0] count_r;
   wire doWr;
   wire doRd;
   integer i;

   assign inReady = (count_r != DEPTH[AW:0]);
   assign outValid = (count_r != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_r];
   assign doWr = inValid & inReady;
   assign doRd = outValid & outReady;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (doWr) begin
            mem[wrPtr_r] <= inData;
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (doRd) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
         if (doWr && !doRd) begin
            count_r <= count_r + 1'b1;
         end else if (doRd && !doWr) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

/* core/psi_sys_if.v */
`timescale 1ns/10ps
`include "psi_defines.vh"
module psi_sys_if (
   input wire clk_sys,
   input wire rst_n,
   // user request side
   input wire reqValid,
   output wire reqReady,
   input wire [1:0] reqKind,
   input wire [63:0] reqAddr,
   input wire [63:0] reqData,
   // user receive side
   output reg rxValid,
   output reg [63:0] rxData,
   output reg [8:0] rxCmd,
   output reg rxCheckErr,
   output reg invalDone,
   output reg invalFailed,
   output wire busySlave,
   input wire multiprocessor_package_config,
   // system interface pins
   input wire [63:0] sys_addr_data_bus_in,
   output reg [63:0] sys_addr_data_bus_out,
   output reg sys_addr_data_bus_oe_n,
   input wire [7:0] sys_addr_data_check_in,
   output reg [7:0] sys_addr_data_check_out,
   input wire [8:0] sys_command_id_bus_in,
   output reg [8:0] sys_command_id_bus_out,
   input wire sys_command_parity_in,
   output reg sys_command_parity_out,
   output reg sys_cmd_oe_n,
   input wire agent_valid_strobe,
   output reg proc_valid_strobe,
   input wire agent_bus_request,
   output reg release_out,
   input wire read_accept_ready,
   input wire write_accept_ready,
   input wire invalidate_ack,
   input wire invalidate_error
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // byte-wise even parity as check field
   function [7:0] adCheck;
      input [63:0] v;
      integer b;
      begin
         adCheck = 8'h00;
         for (b = 0; b < 8; b = b + 1) begin
            adCheck[b] = ^v[b*8 +: 8];
         end
      end
   endfunction

   function cmdParity;
      input [8:0] c;
      begin
         cmdParity = ^c;
      end
   endfunction

   // ----------------------------------------
   // request buffer
   // ----------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_WAIT = 3'h3;
   localparam ST_SLAVE = 3'h4;

   wire [74:0] fifoIn;
   wire [74:0] head;
   wire headValid;
   wire headPop;
   wire [1:0] headKind;
   wire headReady;
   reg [2:0] state_r;
   reg [2:0] state_nxt;

   assign fifoIn = {reqKind, 9'h000, (reqKind == `PSI_KIND_READ) ||
      (reqKind == `PSI_KIND_INVAL) ? reqAddr : reqData};

   psi_fifo #(
      .WIDTH(`PSI_ENT_W),
      .DEPTH(`PSI_FIFO_DEPTH),
      .AW(`PSI_FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inValid(reqValid),
      .inReady(reqReady),
      .inData(fifoIn),
      .outValid(headValid),
      .outReady(headPop),
      .outData(head)
   );

   assign headKind = head[74:73];
   // flow control per request class
   assign headReady = (headKind == `PSI_KIND_WRITE) ?
      write_accept_ready : read_accept_ready;
   assign busySlave = (state_r == ST_SLAVE);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // address word then, for write/update, one data word
   reg [1:0] kind_r;
   reg [63:0] reqDataHold_r;
   assign headPop = (state_r == ST_IDLE) && headValid && headReady &&
      !agent_bus_request;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (agent_bus_request) begin
               state_nxt = ST_SLAVE;
            end else if (headPop) begin
               state_nxt = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (kind_r == `PSI_KIND_WRITE || kind_r == `PSI_KIND_UPDATE)
            begin
               state_nxt = ST_DATA;
            end else if (kind_r == `PSI_KIND_INVAL &&
               multiprocessor_package_config) begin
               state_nxt = ST_WAIT;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_DATA: begin
            if (kind_r == `PSI_KIND_UPDATE && multiprocessor_package_config)
            begin
               state_nxt = ST_WAIT;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (invalidate_ack || invalidate_error) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_SLAVE: begin
            if (!agent_bus_request && !agent_valid_strobe) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // drive side
   // ----------------------------------------
   wire driveAddr;
   wire driveData;
   wire [8:0] cmdWord;
   wire [63:0] word;
   assign driveAddr = (state_nxt == ST_ADDR);
   assign driveData = (state_nxt == ST_DATA);
   assign cmdWord = driveAddr ? {1'b0, 6'h00, headKind} :
      {1'b1, 6'h00, kind_r};
   assign word = driveAddr ? head[63:0] : reqDataHold_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         kind_r <= 2'h0;
         reqDataHold_r <= 64'h0000000000000000;
         sys_addr_data_bus_out <= 64'h0000000000000000;
         sys_addr_data_check_out <= 8'h00;
         sys_command_id_bus_out <= 9'h000;
         sys_command_parity_out <= 1'b0;
         sys_addr_data_bus_oe_n <= 1'b1;
         sys_cmd_oe_n <= 1'b1;
         proc_valid_strobe <= 1'b0;
         release_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (headPop) begin
            kind_r <= headKind;
            reqDataHold_r <= head[63:0];
         end
         // outputs registered with the word they qualify
         proc_valid_strobe <= driveAddr | driveData;
         sys_addr_data_bus_oe_n <= !(driveAddr | driveData);
         sys_cmd_oe_n <= !(driveAddr | driveData);
         if (driveAddr | driveData) begin
            sys_addr_data_bus_out <= word;
            sys_addr_data_check_out <= adCheck(word);
            sys_command_id_bus_out <= cmdWord;
            sys_command_parity_out <= cmdParity(cmdWord);
         end
         // one-cycle release as mastership passes over
         release_out <= (state_r == ST_IDLE) &&
            (state_nxt == ST_SLAVE);
      end
   end

   // ----------------------------------------
   // receive side
   // ----------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxValid <= 1'b0;
         rxData <= 64'h0000000000000000;
         rxCmd <= 9'h000;
         rxCheckErr <= 1'b0;
         invalDone <= 1'b0;
         invalFailed <= 1'b0;
      end else begin
         // only strobed cycles carry a word
         rxValid <= agent_valid_strobe;
         if (agent_valid_strobe) begin
            rxData <= sys_addr_data_bus_in;
            rxCmd <= sys_command_id_bus_in;
            rxCheckErr <= (adCheck(sys_addr_data_bus_in) !=
               sys_addr_data_check_in) ||
               (cmdParity(sys_command_id_bus_in) !=
               sys_command_parity_in);
         end
         invalDone <= (state_r == ST_WAIT) && invalidate_ack;
         invalFailed <= (state_r == ST_WAIT) && !invalidate_ack &&
            invalidate_error;
      end
   end
endmodule

/* sim/psi_sys_if_assertions.sv */
`timescale 1ns/10ps
module psi_sys_if_assertions (
   input wire clk_sys,
   input wire rst_n,
   input wire [63:0] sys_addr_data_bus_out,
   input wire sys_addr_data_bus_oe_n,
   input wire [7:0] sys_addr_data_check_out,
   input wire [8:0] sys_command_id_bus_out,
   input wire sys_command_parity_out,
   input wire sys_cmd_oe_n,
   input wire proc_valid_strobe,
   input wire release_out,
   input wire agent_bus_request,
   input wire read_accept_ready,
   input wire write_accept_ready
);
   wire s = proc_valid_strobe;
   wire [8:0] c = sys_command_id_bus_out;
   wire adr = s && !c[8];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   function automatic [7:0] bp(input [63:0] v);
      for (int i = 0; i < 8; i++) bp[i] = ^v[i*8+:8];
   endfunction
   sequence dataWord;
      s && c[8];
   endsequence
   oe_low_a: assert property (s |-> !sys_addr_data_bus_oe_n)
      else $error("strobe while bus not driven");
   cmd_oe_low_a: assert property (s |-> !sys_cmd_oe_n)
      else $error("strobe while command bus not driven");
   oe_idle_a: assert property (!s |-> sys_addr_data_bus_oe_n)
      else $error("bus driven without strobe");
   check_bits_a: assert property (s |->
      sys_addr_data_check_out == bp(sys_addr_data_bus_out))
      else $error("check bits wrong");
   cmd_parity_a: assert property (s |-> sys_command_parity_out == ^c)
      else $error("command parity wrong");
   data_follows_a: assert property (adr && c[0] |=> dataWord)
      else $error("data word missing");
   read_gate_a: assert property (adr && c[1:0] != 2'h1
      |-> $past(read_accept_ready)) else $error("read issued unready");
   write_gate_a: assert property (adr && c[1:0] == 2'h1
      |-> $past(write_accept_ready)) else $error("write issued unready");
   release_pulse_a: assert property (release_out |=> !release_out)
      else $error("release longer than a cycle");
   release_cause_a: assert property (release_out |->
      $past(agent_bus_request)) else $error("release without request");
endmodule
bind psi_sys_if psi_sys_if_assertions u_chk (.*);

/* sim/psi_agent_model.sv */
`timescale 1ns/10ps
module psi_agent_model (
   input wire clk_sys,
   input wire rst_n,
   input wire multiprocessor_package_config,
   input wire stall,
   input wire agentGo,
   input wire [63:0] agentWord,
   input wire agentBad,
   input wire proc_valid_strobe,
   input wire [8:0] sys_command_id_bus_out,
   input wire release_out,
   output reg [63:0] mAd,
   output reg [7:0] mChk,
   output reg [8:0] mCmd,
   output reg mPar,
   output reg agent_valid_strobe,
   output reg agent_bus_request,
   output reg read_accept_ready,
   output reg write_accept_ready,
   output reg invalidate_ack,
   output reg invalidate_error
);
   reg [1:0] waitCnt;
   reg fail;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {agent_valid_strobe, agent_bus_request, waitCnt} <= 4'h0;
         {read_accept_ready, write_accept_ready} <= 2'h0;
         {invalidate_ack, invalidate_error} <= 2'h0;
         {mAd, mChk, mCmd, mPar} <= 82'h0;
      end else begin
         fail = $urandom % 2;
         read_accept_ready <= !stall && $urandom % 4 != 0;
         write_accept_ready <= !stall && $urandom % 4 != 0;
         {invalidate_ack, invalidate_error} <= 2'h0;
         agent_valid_strobe <= 1'b0;
         // released lines toggle so the check bits of a stale value mismatch on every other cycle
         {mAd, mChk, mCmd, mPar} <= ~{mAd, mChk, mCmd, mPar};
         if (waitCnt != 2'h0) waitCnt <= waitCnt - 2'h1;
         if (waitCnt == 2'h1) begin
            {invalidate_ack, invalidate_error} <= {!fail, fail};
         end
         if (multiprocessor_package_config && proc_valid_strobe &&
            !sys_command_id_bus_out[8] && sys_command_id_bus_out[1]) begin
            waitCnt <= 2'h3;
         end
         if (agentGo) agent_bus_request <= 1'b1;
         if (agent_bus_request && release_out) begin
            agent_bus_request <= 1'b0;
            agent_valid_strobe <= 1'b1;
            mAd <= agentWord;
            for (int i = 0; i < 8; i++) mChk[i] <= ^agentWord[i*8+:8];
            mCmd <= 9'h100;
            mPar <= !agentBad;
         end
      end
   end
endmodule

/* sim/psi_sys_if_bench.sv */
`timescale 1ns/10ps
module psi_sys_if_bench;
   logic clk_sys = 0, rst_n = 0, reqValid = 0, stall = 0;
   logic agentGo = 0, agentBad = 0, expBad = 0;
   logic multiprocessor_package_config = 1;
   logic [1:0] reqKind = 0;
   logic [63:0] reqAddr = 0, reqData = 0, agentWord = 0, expRx = 0;
   logic [65:0] q[$], e;
   int errors = 0, total_checks = 0, cyc = 0;
   int nAck = 0, nErr = 0, nDone = 0, nFail = 0, nSent = 0, nRx = 0;
   wire reqReady, rxValid, rxCheckErr, invalDone, invalFailed, busySlave;
   wire [63:0] rxData, sys_addr_data_bus_out, mAd, sys_addr_data_bus_in;
   wire [8:0] rxCmd, sys_command_id_bus_out, mCmd, sys_command_id_bus_in;
   wire [7:0] sys_addr_data_check_out, mChk, sys_addr_data_check_in;
   wire sys_addr_data_bus_oe_n, sys_command_parity_out, sys_cmd_oe_n, mPar;
   wire proc_valid_strobe, release_out, agent_valid_strobe;
   wire agent_bus_request, read_accept_ready, write_accept_ready;
   wire invalidate_ack, invalidate_error, sys_command_parity_in;
   assign sys_addr_data_bus_in =
      sys_addr_data_bus_oe_n ? mAd : sys_addr_data_bus_out;
   assign sys_addr_data_check_in =
      sys_addr_data_bus_oe_n ? mChk : sys_addr_data_check_out;
   assign sys_command_id_bus_in = sys_cmd_oe_n ? mCmd : sys_command_id_bus_out;
   assign sys_command_parity_in = sys_cmd_oe_n ? mPar : sys_command_parity_out;
   psi_sys_if u_psi_sys_if (.*);
   psi_agent_model u_psi_agent_model (.*);
   always #5 clk_sys = ~clk_sys;
   task cmp(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task send(input logic [1:0] k, input logic [63:0] a, input logic [63:0] d);
      @(posedge clk_sys) #1;
      reqValid = 1;
      {reqKind, reqAddr, reqData} = {k, a, d};
      do @(posedge clk_sys); while (reqReady !== 1'b1);
      q.push_back({k, k[0] ? d : a});
      #1 reqValid = 0;
   endtask
   task agent(input logic [63:0] w, input logic b);
      @(posedge clk_sys) #1;
      {agentWord, agentBad, expRx, expBad, agentGo} = {w, b, w, b, 1'b1};
      nSent++;
      @(posedge clk_sys) #1 agentGo = 0;
      for (int i = 0; i < 100 && nRx < nSent; i++) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         give_verdict;
      end
      {nAck, nErr} = {nAck + invalidate_ack, nErr + invalidate_error};
      {nDone, nFail} = {nDone + invalDone, nFail + invalFailed};
      if (rxValid) begin
         nRx++;
         cmp(rxData, expRx);
         cmp(rxCmd, 9'h100);
         cmp(rxCheckErr, expBad);
         cmp(busySlave, 1'b1);
      end
      if (proc_valid_strobe && !sys_command_id_bus_out[8]) begin
         e = q.pop_front();
         cmp(sys_command_id_bus_out[1:0], e[65:64]);
      end
      if (proc_valid_strobe) cmp(sys_addr_data_bus_out, e[63:0]);
      if (proc_valid_strobe) cmp(sys_cmd_oe_n, 1'b0);
      if (proc_valid_strobe) cmp(busySlave, 1'b0);
   end
   initial begin
      int i;
      i = $urandom(36);
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1;
      send(2'h1, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF);
      send(2'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0);
      for (i = 0; i < 40; i++) begin
         send(2'($urandom), {$urandom, $urandom}, {$urandom, $urandom});
         if (i % 8 == 3) agent({$urandom, $urandom}, i[4]);
      end
      // drain first so the fill below starts from an empty buffer
      for (i = 0; i < 900 && q.size() != 0; i++) @(posedge clk_sys);
      // far side stalls: sixteen entries fill the buffer and reqReady drops
      @(posedge clk_sys) #1 stall = 1;
      repeat (30) @(posedge clk_sys);
      for (i = 0; i < 16; i++) send(2'($urandom), {$urandom, $urandom}, 64'h0);
      cmp(reqReady, 0);
      stall = 0;
      for (i = 0; i < 900 && q.size() != 0; i++) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      // single-processor mode: invalidate and update end unanswered
      @(posedge clk_sys) #1 multiprocessor_package_config = 0;
      send(2'h2, {$urandom, $urandom}, 64'h0);
      send(2'h3, 64'h0, {$urandom, $urandom});
      for (i = 0; i < 100 && q.size() != 0; i++) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      cmp(q.size(), 0);
      cmp(nDone, nAck);
      cmp(nFail, nErr);
      cmp(nRx, nSent);
      give_verdict;
   end
endmodule
